// *** src/pwsd_core.sv ***
/*
 * Counter, PWM register synchronisation and dual-edge capture for one channel pair,
 * with its registers on an APB slave (zero wait states).
 * Assumes hw_trig, chan_in and the APB signals are synchronous to clk.
 */
// What this block does
// R1: Sync reloads counter, forces outputs to initial levels
// R2: On_trigger_a clear: sync only on wrap from modulo
// R3: On_trigger_a set, mode zero: sync on trigger
// R4: Initial value accepted after both bytes, applied later
// R5: Mode zero, no on_trigger_a: modulo loads at max/min
// R6: Mode zero, on_trigger_a: modulo loads at trigger itself
// R7: Mode one, max: modulo loads after software trigger
// R8: Mode one, min: modulo loads after software trigger
// R9: Pair sync, mode zero only: channel values follow modulo transfer conditions
// R10: Rising edge captures; falling edge moves to value
// R11: Falling edge captures second; first-value read moves it
// R12: Software reads first channel value before second
// R13: Used hardware trigger clears its enable bit
// R14: Initial value writes go to a buffer
// R15: Modulo and channel writes are buffered until sync
`timescale 1ns/100ps

module pwsd_core #(
	parameter int CW = 16
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Triggers and channel pins
	input  wire logic [2:0]                  hw_trig,
	input  wire logic                        chan_in,
	output logic      [1:0]                  chan_out
);
	import pwsd_pkg::*;

	// Byte-lane merge of a 16-bit register
	// Lanes 3:2 are ignored: no register here is wider than 16 bits
	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] st);
		lane_merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Register select from the byte address
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		reg_hit = a == off;
	endfunction

	logic [PWSD_CTRL_W-1:0] ctrl_reg;
	logic [CW-1:0]          cnt_reg;
	logic [CW-1:0]          init_act_reg;
	logic [CW-1:0]          init_buf_reg;
	logic                   init_lo_reg;
	logic                   init_hi_reg;
	logic                   init_ready_reg;
	logic [CW-1:0]          mod_act_reg;
	logic [CW-1:0]          mod_buf_reg;
	logic [CW-1:0]          chv_act_reg [2];
	logic [CW-1:0]          chv_buf_reg [2];
	logic [CW-1:0]          cap_reg [2];
	logic                   armed_reg;
	logic                   ovf_reg;
	logic                   chin_prev_reg;
	logic [1:0]             out_reg;
	logic [31:0]            prdata_reg;

	// Bus decode
	wire       setup_ph = psel & ~penable;
	wire       wr_acc   = psel & penable & pwrite;
	wire       rd_acc   = psel & penable & ~pwrite;
	wire       sel_ctrl = reg_hit(paddr, PWSD_OFF_CTRL);
	wire       sel_init = reg_hit(paddr, PWSD_OFF_INIT);
	wire       sel_mod  = reg_hit(paddr, PWSD_OFF_MOD);
	wire       sel_ch0  = reg_hit(paddr, PWSD_OFF_CH0V);
	wire       sel_ch1  = reg_hit(paddr, PWSD_OFF_CH1V);
	// Counter is read only; a write to it is dropped without an error
	wire       sel_cnt  = reg_hit(paddr, PWSD_OFF_CNT);
	wire       sel_stat = reg_hit(paddr, PWSD_OFF_STATUS);
	wire       mapped   = sel_ctrl | sel_init | sel_mod | sel_ch0 | sel_ch1 | sel_cnt | sel_stat;
	wire [1:0] lanes    = pstrb[1:0];

	// Control fields
	wire       cnt_en    = ctrl_reg[PWSD_CTRL_CNT_EN];
	wire       on_trigger_a    = ctrl_reg[PWSD_CTRL_ON_TRIGGER_A];
	wire       tms       = ctrl_reg[PWSD_CTRL_TMS];
	wire       ld_max    = ctrl_reg[PWSD_CTRL_LD_MAX];
	wire       ld_min    = ctrl_reg[PWSD_CTRL_LD_MIN];
	wire       sw_sync   = ctrl_reg[PWSD_CTRL_SW_SYNC];
	wire       pair_sync = ctrl_reg[PWSD_CTRL_PAIR_SYNC];
	wire       dual_cap  = ctrl_reg[PWSD_CTRL_DUAL_CAP];
	wire [1:0] init_lvl  = ctrl_reg[PWSD_CTRL_INIT_LVL +: 2];
	wire [2:0] hw_en     = ctrl_reg[PWSD_CTRL_HW_EN +: 3];

	// Trigger handling: in mode one hardware triggers are ignored and keep their enables
	wire hw_ev     = |(hw_trig & hw_en);
	wire trig_take = tms ? sw_sync : (hw_ev | sw_sync);                       // see R7
	wire hw_used   = trig_take & ~tms;                                        // see R13
	// Triggers are levels: one held high fires again while its enable is still set

	// Hardware clears of the control register; only the enables that fired are dropped
	wire       sw_clr     = trig_take & sw_sync;                              // see R3
	wire [2:0] hw_en_kept = hw_used ? (hw_en & ~hw_trig) : hw_en;             // see R13

	// Counter events
	wire at_max    = cnt_reg == mod_act_reg;
	// Minimum is the initial value, not zero, so a moved start point moves the load point too
	wire at_min    = cnt_reg == init_act_reg;
	wire wrap      = cnt_en & at_max;                                         // see R2
	wire cnt_sync  = wrap | (on_trigger_a & ~tms & trig_take);                      // see R3
	wire load_pt   = cnt_en & ((ld_max & ~ld_min & at_max) | (ld_min & ~ld_max & at_min));
	// Both or neither load point set: an armed transfer waits until software picks one
	wire imm_mode  = ~tms & on_trigger_a;
	wire xfer      = imm_mode ? trig_take : (armed_reg & load_pt);           // see R5 see R6 see R8
	// In capture mode the value registers belong to the capture path
	wire ch_xfer   = xfer & pair_sync & ~tms & ~dual_cap;                     // see R9
	wire [CW-1:0] init_next = init_ready_reg ? init_buf_reg : init_act_reg;  // see R4

	// Dual-edge capture
	wire rise      = dual_cap & chan_in & ~chin_prev_reg;
	wire fall      = dual_cap & ~chan_in & chin_prev_reg;
	wire ch0_read  = rd_acc & sel_ch0 & dual_cap;

	// Register writes
	wire [15:0] ctrl_wr  = lane_merge({3'b000, ctrl_reg}, pwdata[15:0], lanes);
	wire        ctrl_we  = wr_acc & sel_ctrl;
	wire        init_we  = wr_acc & sel_init;
	wire        lo_now   = init_lo_reg | (init_we & lanes[0]);
	wire        hi_now   = init_hi_reg | (init_we & lanes[1]);
	wire        init_cpl = lo_now & hi_now;

	// Read mux, sampled in the setup phase
	// Loading on the setup edge lets the slave answer with no wait state
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (1'b1)
			sel_ctrl: rd_mux[PWSD_CTRL_W-1:0] = ctrl_reg;
			sel_init: rd_mux[CW-1:0] = init_act_reg;
			sel_mod:  rd_mux[CW-1:0] = mod_act_reg;
			sel_ch0:  rd_mux[CW-1:0] = chv_act_reg[0];
			sel_ch1:  rd_mux[CW-1:0] = chv_act_reg[1];
			sel_cnt:  rd_mux[CW-1:0] = cnt_reg;
			sel_stat: rd_mux[2:0] = {out_reg, ovf_reg};
			default:  rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			prdata_reg <= rd_mux;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	// Unmapped offsets answer with an error and read as zero
	assign pslverr = psel & penable & ~mapped;

	// Control: a software write wins over the hardware clears of the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= PWSD_CTRL_RST;
		end else if (ctrl_we) begin
			ctrl_reg <= ctrl_wr[PWSD_CTRL_W-1:0];
		end else begin
			if (sw_clr)
				ctrl_reg[PWSD_CTRL_SW_SYNC] <= 1'b0;                          // see R3
			ctrl_reg[PWSD_CTRL_HW_EN +: 3] <= hw_en_kept;                   // see R13
		end
	end

	// Counter initial value: buffered until both bytes are in, applied at overflow or sync
	// Byte flags collect the two halves; a half write made while a complete value is still pending reaches the counter with it at the next sync
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			init_buf_reg   <= PWSD_ZERO_RST[CW-1:0];
			init_act_reg   <= PWSD_ZERO_RST[CW-1:0];
			init_lo_reg    <= 1'b0;
			init_hi_reg    <= 1'b0;
			init_ready_reg <= 1'b0;
		end else begin
			if (init_we)
				init_buf_reg <= lane_merge(init_buf_reg, pwdata[15:0], lanes);  // see R14
			init_lo_reg <= lo_now & ~init_cpl;
			init_hi_reg <= hi_now & ~init_cpl;
			if (cnt_sync)
				init_act_reg <= init_next;                                    // see R4
			if (init_cpl)
				init_ready_reg <= 1'b1;
			else if (cnt_sync)
				init_ready_reg <= 1'b0;
		end
	end

	// Counter and overflow flag (write one to clear, a new overflow wins)
	// A counter above a lowered modulo runs up to all ones before it comes round
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= PWSD_ZERO_RST[CW-1:0];
			ovf_reg <= 1'b0;
		end else begin
			if (cnt_sync)
				cnt_reg <= init_next;                                         // see R1
			else if (cnt_en)
				cnt_reg <= cnt_reg + 1'b1;
			if (wrap)
				ovf_reg <= 1'b1;
			else if (wr_acc && sel_stat && lanes[0] && pwdata[PWSD_STAT_OVF])
				ovf_reg <= 1'b0;
		end
	end

	// Modulo: buffered write, moved only at the synchronisation point
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mod_buf_reg <= PWSD_MOD_RST[CW-1:0];
			mod_act_reg <= PWSD_MOD_RST[CW-1:0];
			armed_reg   <= 1'b0;
		end else begin
			if (wr_acc && sel_mod)
				mod_buf_reg <= lane_merge(mod_buf_reg, pwdata[15:0], lanes);    // see R15
			if (xfer)
				mod_act_reg <= mod_buf_reg;                                   // see R5 see R6 see R7
			armed_reg <= trig_take | (armed_reg & ~xfer);
		end
	end

	// Channel write buffers, and the output level each channel takes next
	logic [1:0] out_next;
	generate
		for (genvar g = 0; g < 2; g++) begin : g_ch
			wire ch_we  = wr_acc & (g == 0 ? sel_ch0 : sel_ch1);
			wire ch_hit = cnt_en & (cnt_reg == chv_act_reg[g]);
			// A sync and a match in one cycle: the sync wins, so a period starts clean
			assign out_next[g] = cnt_sync ? init_lvl[g] : (ch_hit ? ~init_lvl[g] : out_reg[g]);  // see R1
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					chv_buf_reg[g] <= PWSD_ZERO_RST[CW-1:0];
				end else if (ch_we) begin
					chv_buf_reg[g] <= lane_merge(chv_buf_reg[g], pwdata[15:0], lanes);  // see R15
				end
			end
		end
	endgenerate

	// Both output bits live in one register, so the vector has a single writer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_reg <= 2'h0;
		end else begin
			out_reg <= out_next;
		end
	end

	// Capture buffers follow the input edges
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chin_prev_reg <= 1'b0;
			cap_reg[0]    <= PWSD_ZERO_RST[CW-1:0];
			cap_reg[1]    <= PWSD_ZERO_RST[CW-1:0];
		end else begin
			chin_prev_reg <= chan_in;
			if (rise)
				cap_reg[0] <= cnt_reg;                                        // see R10
			if (fall)
				cap_reg[1] <= cnt_reg;                                        // see R11
		end
	end

	// Value registers: a capture move wins over a buffered transfer.
	// The second value moves only on the first value's read, so software sees a matched pair.
	wire [CW-1:0] chv0_next = fall ? cap_reg[0] : (ch_xfer ? chv_buf_reg[0] : chv_act_reg[0]);      // see R10 see R9
	wire [CW-1:0] chv1_next = ch0_read ? cap_reg[1] : (ch_xfer ? chv_buf_reg[1] : chv_act_reg[1]);  // see R11 see R9

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chv_act_reg[0] <= PWSD_ZERO_RST[CW-1:0];
			chv_act_reg[1] <= PWSD_ZERO_RST[CW-1:0];
		end else begin
			chv_act_reg[0] <= chv0_next;
			chv_act_reg[1] <= chv1_next;
		end
	end

	assign chan_out = out_reg;

endmodule

// *** src/pwsd_pkg.sv ***
/*
 * Shared constants of the timer synchronisation and dual-edge capture block:
 * register offsets, control field positions and reset values.
 * Assumes a 32-bit APB with byte addresses; every register is one aligned word.
 */
package pwsd_pkg;

	// Register byte offsets
	localparam logic [7:0] PWSD_OFF_CTRL   = 8'h00;
	localparam logic [7:0] PWSD_OFF_INIT   = 8'h04;
	localparam logic [7:0] PWSD_OFF_MOD    = 8'h08;
	localparam logic [7:0] PWSD_OFF_CH0V   = 8'h0C;
	localparam logic [7:0] PWSD_OFF_CH1V   = 8'h10;
	localparam logic [7:0] PWSD_OFF_CNT    = 8'h14;
	localparam logic [7:0] PWSD_OFF_STATUS = 8'h18;

	// Control register field positions
	localparam int PWSD_CTRL_CNT_EN    = 0;
	localparam int PWSD_CTRL_ON_TRIGGER_A    = 1;
	localparam int PWSD_CTRL_TMS       = 2;
	localparam int PWSD_CTRL_LD_MAX    = 3;
	localparam int PWSD_CTRL_LD_MIN    = 4;
	localparam int PWSD_CTRL_SW_SYNC   = 5;
	localparam int PWSD_CTRL_PAIR_SYNC = 6;
	localparam int PWSD_CTRL_DUAL_CAP  = 7;
	localparam int PWSD_CTRL_INIT_LVL  = 8;
	localparam int PWSD_CTRL_HW_EN     = 10;
	localparam int PWSD_CTRL_W         = 13;

	// Status register field positions
	localparam int PWSD_STAT_OVF = 0;
	localparam int PWSD_STAT_OUT = 1;

	// Reset values
	localparam logic [PWSD_CTRL_W-1:0] PWSD_CTRL_RST = 13'h0000;
	localparam logic [15:0]            PWSD_MOD_RST  = 16'hFFFF;
	localparam logic [15:0]            PWSD_ZERO_RST = 16'h0000;

endpackage

// *** verification/pwsd_checker.sv ***
/* Checker for pwsd_core: sync output levels, control clears and APB answers.
   Assumes a bind to pwsd_core; CTRL is shadowed from APB writes and the trigger clears. */
`timescale 1ns/100ps
module pwsd_checker
	import pwsd_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins
	input wire logic [2:0]  hw_trig,
	input wire logic [1:0]  chan_out
);
	logic [12:0] ctrl_reg;
	wire acc = psel & penable;
	wire wr_ctrl = acc & pwrite & (paddr == PWSD_OFF_CTRL);
	wire mapped = paddr inside {PWSD_OFF_CTRL, PWSD_OFF_INIT, PWSD_OFF_MOD, PWSD_OFF_CH0V,
		PWSD_OFF_CH1V, PWSD_OFF_CNT, PWSD_OFF_STATUS};
	wire taken = ctrl_reg[5] | (~ctrl_reg[2] & |(hw_trig & ctrl_reg[12:10]));

	// Software write wins over the hardware clears, as in the design
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= '0;
		end else if (wr_ctrl) begin
			if (pstrb[0]) ctrl_reg[7:0] <= pwdata[7:0];
			if (pstrb[1]) ctrl_reg[12:8] <= pwdata[12:8];
		end else if (taken) begin
			ctrl_reg[5] <= 1'b0;
			if (!ctrl_reg[2]) ctrl_reg[12:10] <= ctrl_reg[12:10] & ~hw_trig;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sync_out_a:
		assert property (ctrl_reg[1] && !ctrl_reg[2] && taken && !wr_ctrl |=> chan_out == ctrl_reg[9:8])
		else $error("outputs not at initial level after sync");
	ctrl_read_a:
		assert property (acc && !pwrite && paddr == PWSD_OFF_CTRL |-> prdata == {19'h0, $past(ctrl_reg)})
		else $error("control readback wrong");
	pready_high_a:
		assert property (acc |-> pready) else $error("access without ready");
	unmapped_err_a:
		assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped access");
	mapped_ok_a:
		assert property (acc && mapped |-> !pslverr) else $error("error on mapped access");
	idle_no_err_a:
		assert property (!acc |-> !pslverr) else $error("error outside access");
	unmapped_zero_a:
		assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
	read_hold_a:
		assert property (acc && !pwrite |=> $stable(prdata)) else $error("read data moved");
endmodule

bind pwsd_core pwsd_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.hw_trig(hw_trig), .chan_out(chan_out));

// *** verification/pwm_sync_and_dual_edge_capture_tb.sv ***
/* Self-checking bench for pwsd_core over APB.
   Assumes zero wait states are not relied on; the watchdog ends a hang. */
`timescale 1ns/100ps
module pwm_sync_and_dual_edge_capture_tb;
	import pwsd_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'h0;
	logic [2:0]  hw_trig = 3'h0;
	logic        chan_in = 1'b0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire  [1:0]  chan_out;
	logic [31:0] rd_q;
	logic        err_q;
	int          fail_count = 0;
	int          cmp_count = 0;

	always #10 clk = ~clk;

	pwsd_core u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hw_trig(hw_trig), .chan_in(chan_in), .chan_out(chan_out));

	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, d, 4'b0011);
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 16'h0000, 4'b0000);
		chk(n, e, rd_q);
	endtask

	task automatic pulse_trig;
		@(posedge clk);
		hw_trig <= 3'b001;
		@(posedge clk);
		hw_trig <= 3'b000;
	endtask

	task automatic results;
		$display("checks %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic t_reset;
		rd(PWSD_OFF_CTRL, 32'h0000_0000, "ctrl");
		rd(PWSD_OFF_MOD, 32'h0000_FFFF, "mod");
		rd(8'h1C, 32'h0000_0000, "unmapped");
		chk("pslverr", 32'h0000_0001, {31'h0, err_q});
		$display("reset test done");
	endtask

	task automatic t_trig;
		wr(PWSD_OFF_MOD, 16'h0005);
		wr(PWSD_OFF_CH0V, 16'h0004);
		rd(PWSD_OFF_MOD, 32'h0000_FFFF, "mod held");
		rd(PWSD_OFF_CH0V, 32'h0000_0000, "ch0 held");
		wr(PWSD_OFF_CTRL, 16'h0542);
		pulse_trig();
		rd(PWSD_OFF_MOD, 32'h0000_0005, "mod on trigger");
		rd(PWSD_OFF_CH0V, 32'h0000_0004, "ch0 on trigger");
		rd(PWSD_OFF_CTRL, 32'h0000_0142, "hw enable");
		rd(PWSD_OFF_STATUS, 32'h0000_0002, "status after sync");
		chk("chan_out", 32'h0000_0001, {30'h0, chan_out});
		$display("trigger test done");
	endtask

	task automatic t_sw;
		wr(PWSD_OFF_MOD, 16'h0003);
		wr(PWSD_OFF_CTRL, 16'h0029);
		repeat (12) @(posedge clk);
		rd(PWSD_OFF_MOD, 32'h0000_0003, "mod at max");
		wr(PWSD_OFF_MOD, 16'h0007);
		wr(PWSD_OFF_CTRL, 16'h040D);
		pulse_trig();
		repeat (12) @(posedge clk);
		rd(PWSD_OFF_MOD, 32'h0000_0003, "mod hw ignored");
		wr(PWSD_OFF_CTRL, 16'h002D);
		repeat (12) @(posedge clk);
		rd(PWSD_OFF_MOD, 32'h0000_0007, "mod after sw");
		rd(PWSD_OFF_CTRL, 32'h0000_000D, "sw bit");
		wr(PWSD_OFF_MOD, 16'h0006);
		wr(PWSD_OFF_CTRL, 16'h0035);
		repeat (12) @(posedge clk);
		rd(PWSD_OFF_MOD, 32'h0000_0006, "mod at min");
		$display("software trigger test done");
	endtask

	task automatic t_init;
		wr(PWSD_OFF_CTRL, 16'h0022);
		apb(1'b1, PWSD_OFF_INIT, 16'h0002, 4'b0001);
		rd(PWSD_OFF_INIT, 32'h0000_0000, "init one byte");
		apb(1'b1, PWSD_OFF_INIT, 16'h0000, 4'b0010);
		repeat (12) @(posedge clk);
		rd(PWSD_OFF_INIT, 32'h0000_0000, "init waits");
		wr(PWSD_OFF_CTRL, 16'h0001);
		repeat (12) @(posedge clk);
		rd(PWSD_OFF_INIT, 32'h0000_0002, "init after wrap");
		apb(1'b0, PWSD_OFF_STATUS, 16'h0000, 4'b0000);
		chk("ovf", 32'h0000_0001, {31'h0, rd_q[0]});
		$display("initial value test done");
	endtask

	task automatic t_cap;
		wr(PWSD_OFF_CTRL, 16'h00A2);
		rd(PWSD_OFF_CNT, 32'h0000_0002, "count after sync");
		chan_in <= 1'b1;
		repeat (2) @(posedge clk);
		rd(PWSD_OFF_CH0V, 32'h0000_0004, "ch0 before fall");
		chan_in <= 1'b0;
		repeat (2) @(posedge clk);
		rd(PWSD_OFF_CH1V, 32'h0000_0000, "ch1 early");
		rd(PWSD_OFF_CH0V, 32'h0000_0002, "ch0 after fall");
		rd(PWSD_OFF_CH1V, 32'h0000_0002, "ch1 after ch0");
		$display("capture test done");
	endtask

	initial begin
		repeat (2000) @(posedge clk);
		fail_count++;
		results();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_trig();
		t_sw();
		t_init();
		t_cap();
		results();
	end
endmodule
